// ### common/pcs_defines.vh
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH

// Register indices; byte address is four times the index
`define PCS_IDX_IND_PORT 8'h00
`define PCS_IDX_PC_LOW 8'h02
`define PCS_IDX_BANK 8'h03
`define PCS_IDX_POINTER 8'h04
`define PCS_IDX_PC_LATCH 8'h0A
`define PCS_IDX_PERIPH_FLAG 8'h0C
`define PCS_IDX_RESET_CAUSE 8'h8E

// Widths
`define PCS_PC_W 13
`define PCS_STACK_DEPTH 8
`define PCS_SP_W 3
`define PCS_DATA_AW 9
`define PCS_DATA_DEPTH 512

// Peripheral flag register fields
`define PCS_PF_PORT_BIT 7
`define PCS_PF_CMP_BIT 6

// Reset cause register fields
`define PCS_RC_PARITY_EN_BIT 7
`define PCS_RC_PARITY_BIT 2
`define PCS_RC_POWERON_BIT 1
`define PCS_RC_BROWNOUT_BIT 0

// Bank select register field
`define PCS_BANK_BIT 7

// Program counter high latch fields
`define PCS_LATCH_W 5
`define PCS_LATCH_PAGE_BIT 3
`define PCS_LATCH_UNUSED_BIT 4
`define PCS_GOTO_W 11

// Reset values
`define PCS_PC_RESET 13'h0000
`define PCS_BYTE_ZERO 8'h00
`define PCS_LATCH_RESET 5'h00
`define PCS_SP_RESET 3'h0
`define PCS_SP_ONE 3'h1
`define PCS_PC_ONE 13'h0001
`define PCS_WORD_ZERO 32'h0000_0000

// Indirect port seen through the pointer (low seven bits)
`define PCS_IND_SELF 7'h00

// Interrupt vector
`define PCS_IRQ_VECTOR 13'h0004

`endif

// ### design/pcs_core.v
// Implementation choice: the APB register port.
`timescale 1ns/1ns
`include "pcs_defines.vh"

module pcs_core (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   // Device reset causes, one-cycle pulses
   input wire poweron_rst_evt,
   input wire brownout_rst_evt,
   input wire parity_rst_evt,
   // Configuration word bits
   input wire parity_check_fuse,
   input wire brownout_detect_fuse,
   // Peripheral events
   input wire port_transfer_evt,
   input wire [1:0] cmp_out,
   // Instruction decoder requests
   input wire fetch_inc,
   input wire call_en,
   input wire goto_en,
   input wire [10:0] branch_target,
   input wire return_en,
   input wire irq_vector_en,
   input wire pc_low_load,
   input wire [7:0] pc_low_data,
   // Program counter and indirect address
   output wire [12:0] pc,
   output wire [8:0] ind_addr
);

   // State
   reg [`PCS_PC_W-1:0] pc_r;
   reg [`PCS_LATCH_W-1:0] pc_high_latch_r;
   reg [7:0] pointer_r;
   reg bank_r;
   reg [`PCS_PC_W-1:0] stack_mem [0:`PCS_STACK_DEPTH-1];
   reg [`PCS_SP_W-1:0] sp_r;
   reg [7:0] data_mem [0:`PCS_DATA_DEPTH-1];
   reg port_transfer_flag_r;
   reg compare_change_flag_r;
   reg [1:0] cmp_prev_r;
   reg cmp_valid_r;
   reg parity_status_r;
   reg poweron_status_r;
   reg brownout_reset_status_r;

   // Combinational next values
   reg [`PCS_PC_W-1:0] pc_nxt;
   reg [`PCS_SP_W-1:0] sp_nxt;
   reg push;
   reg port_transfer_flag_nxt;
   reg compare_change_flag_nxt;
   reg parity_status_nxt;
   reg poweron_status_nxt;
   reg brownout_reset_status_nxt;
   reg [31:0] prdata_nxt;

   // Decode and datapath nets
   wire [7:0] idx;
   wire wr_acc;
   wire rd_setup;
   wire mapped;
   wire any_reset;
   wire ind_self;
   wire cmp_change;
   wire [7:0] ind_rdata;
   wire [`PCS_LATCH_W-1:0] latch_up;
   wire [`PCS_PC_W-1:0] branch_dest;
   wire wr_ind_port;
   wire wr_pc_low;
   wire wr_bank;
   wire wr_pointer;
   wire wr_pc_latch;
   wire wr_flags;
   wire wr_cause;

   // Upper PC bits from the latch; the top latch bit never reaches the PC
   function [4:0] latch_upper;
      input [`PCS_LATCH_W-1:0] latch;
      begin
         latch_upper = {1'b0, latch[`PCS_LATCH_W-2:0]};
      end
   endfunction

   // Register index from a byte address
   function [7:0] reg_index;
      input [31:0] addr;
      begin
         reg_index = addr[9:2];
      end
   endfunction

   // Register index decode
   function is_mapped;
      input [7:0] i;
      begin
         case (i)
            `PCS_IDX_IND_PORT, `PCS_IDX_PC_LOW, `PCS_IDX_BANK,
            `PCS_IDX_POINTER, `PCS_IDX_PC_LATCH,
            `PCS_IDX_PERIPH_FLAG, `PCS_IDX_RESET_CAUSE: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   // Word-aligned addresses inside the decoded window only
   function addr_ok;
      input [31:0] addr;
      begin
         addr_ok = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'h0);
      end
   endfunction

   // Write strobe for one register index
   function reg_hit;
      input [7:0] i;
      input [7:0] target;
      input strobe;
      begin
         reg_hit = strobe && (i == target);
      end
   endfunction

   // APB: zero wait states, error on unmapped or unaligned word
   assign idx = reg_index(paddr);
   assign mapped = is_mapped(idx) && addr_ok(paddr);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wr_acc = psel & penable & pwrite & mapped;

   // Read data is captured in the setup cycle so access needs no wait
   assign rd_setup = psel & ~penable & ~pwrite;

   // Per-register write strobes, access phase only
   assign wr_ind_port = reg_hit(idx, `PCS_IDX_IND_PORT, wr_acc);
   assign wr_pc_low = reg_hit(idx, `PCS_IDX_PC_LOW, wr_acc);
   assign wr_bank = reg_hit(idx, `PCS_IDX_BANK, wr_acc);
   assign wr_pointer = reg_hit(idx, `PCS_IDX_POINTER, wr_acc);
   assign wr_pc_latch = reg_hit(idx, `PCS_IDX_PC_LATCH, wr_acc);
   assign wr_flags = reg_hit(idx, `PCS_IDX_PERIPH_FLAG, wr_acc);
   assign wr_cause = reg_hit(idx, `PCS_IDX_RESET_CAUSE, wr_acc);

   // Any device reset source
   assign any_reset = rst | poweron_rst_evt | brownout_rst_evt | parity_rst_evt;

   // Indirect address and self-reference check
   assign ind_addr = {bank_r, pointer_r};
   assign ind_self = (pointer_r[6:0] == `PCS_IND_SELF);
   assign ind_rdata = ind_self ? `PCS_BYTE_ZERO : data_mem[ind_addr];

   assign pc = pc_r;

   // Upper PC bits as the latch presents them
   assign latch_up = latch_upper(pc_high_latch_r);

   // Call and jump target: page from the latch, low bits from the opcode
   assign branch_dest = {latch_up[`PCS_LATCH_W-1:`PCS_LATCH_PAGE_BIT], branch_target};

   // Comparator change detect, armed after first sample
   assign cmp_change = cmp_valid_r & (cmp_out != cmp_prev_r);

   // Next PC and stack pointer
   always @* begin
      pc_nxt = pc_r;
      sp_nxt = sp_r;
      push = 1'b0;
      if (irq_vector_en) begin
         push = 1'b1;
         sp_nxt = sp_r + `PCS_SP_ONE;
         pc_nxt = `PCS_IRQ_VECTOR;
      end else if (call_en) begin
         push = 1'b1;
         sp_nxt = sp_r + `PCS_SP_ONE;
         pc_nxt = branch_dest;
      end else if (goto_en) begin
         pc_nxt = branch_dest;
      end else if (return_en) begin
         sp_nxt = sp_r - `PCS_SP_ONE;
         pc_nxt = stack_mem[sp_r - `PCS_SP_ONE];
      end else if (pc_low_load) begin
         pc_nxt = {latch_up, pc_low_data};
      end else if (wr_pc_low) begin
         pc_nxt = {latch_up, pwdata[7:0]};
      end else if (fetch_inc) begin
         pc_nxt = pc_r + `PCS_PC_ONE;
      end
   end

   // Program counter and stack
   always @(posedge clk_sys) begin
      if (any_reset) begin
         pc_r <= `PCS_PC_RESET;
         sp_r <= `PCS_SP_RESET;
      end else begin
         pc_r <= pc_nxt;
         sp_r <= sp_nxt;
      end
   end

   // Stack storage holds the full PC; no reset needed
   always @(posedge clk_sys) begin
      if (!any_reset && push) begin
         stack_mem[sp_r] <= pc_r;
      end
   end

   // High latch; only a software write changes it, never a push or pop
   always @(posedge clk_sys) begin
      if (any_reset) begin
         pc_high_latch_r <= `PCS_LATCH_RESET;
      end else if (wr_pc_latch) begin
         pc_high_latch_r <= pwdata[`PCS_LATCH_W-1:0];
      end
   end

   // Indirect pointer
   always @(posedge clk_sys) begin
      if (any_reset) begin
         pointer_r <= `PCS_BYTE_ZERO;
      end else if (wr_pointer) begin
         pointer_r <= pwdata[7:0];
      end
   end

   // Indirect bank bit
   always @(posedge clk_sys) begin
      if (any_reset) begin
         bank_r <= 1'b0;
      end else if (wr_bank) begin
         bank_r <= pwdata[`PCS_BANK_BIT];
      end
   end

   // Data store reached only through the indirect port
   always @(posedge clk_sys) begin
      if (wr_ind_port && !ind_self) begin
         data_mem[ind_addr] <= pwdata[7:0];
      end
   end

   // Comparator history
   always @(posedge clk_sys) begin
      if (rst) begin
         cmp_prev_r <= 2'h0;
         cmp_valid_r <= 1'b0;
      end else begin
         cmp_prev_r <= cmp_out;
         cmp_valid_r <= 1'b1;
      end
   end

   // Flag next values: an event sets, a write loads, set wins a clash
   always @* begin
      port_transfer_flag_nxt = port_transfer_flag_r | port_transfer_evt;
      compare_change_flag_nxt = compare_change_flag_r | cmp_change;
      if (wr_flags) begin
         port_transfer_flag_nxt = pwdata[`PCS_PF_PORT_BIT] | port_transfer_evt;
         compare_change_flag_nxt = pwdata[`PCS_PF_CMP_BIT] | cmp_change;
      end
   end

   // Peripheral flag registers, no enable gating
   always @(posedge clk_sys) begin
      if (rst) begin
         port_transfer_flag_r <= 1'b0;
         compare_change_flag_r <= 1'b0;
      end else begin
         port_transfer_flag_r <= port_transfer_flag_nxt;
         compare_change_flag_r <= compare_change_flag_nxt;
      end
   end

   // Reset cause next values: a reset event beats a software write; a brownout event only with brownout_detect_fuse set
   always @* begin
      parity_status_nxt = parity_status_r;
      poweron_status_nxt = poweron_status_r;
      brownout_reset_status_nxt = brownout_reset_status_r;
      if (wr_cause) begin
         parity_status_nxt = pwdata[`PCS_RC_PARITY_BIT];
         poweron_status_nxt = pwdata[`PCS_RC_POWERON_BIT];
         brownout_reset_status_nxt = pwdata[`PCS_RC_BROWNOUT_BIT];
      end
      if (parity_rst_evt) begin
         parity_status_nxt = 1'b0;
      end
      if (poweron_rst_evt) begin
         poweron_status_nxt = 1'b0;
         brownout_reset_status_nxt = brownout_reset_status_r;
      end
      if (brownout_rst_evt && brownout_detect_fuse) begin
         brownout_reset_status_nxt = 1'b0;
      end
   end

   // Reset cause registers; a plain reset counts as power-on
   always @(posedge clk_sys) begin
      if (rst) begin
         parity_status_r <= 1'b1;
         poweron_status_r <= 1'b0;
         brownout_reset_status_r <= 1'b0;
      end else begin
         parity_status_r <= parity_status_nxt;
         poweron_status_r <= poweron_status_nxt;
         brownout_reset_status_r <= brownout_reset_status_nxt;
      end
   end

   // Read data mux; unimplemented bits read zero
   always @* begin
      prdata_nxt = `PCS_WORD_ZERO;
      case (idx)
         `PCS_IDX_IND_PORT: prdata_nxt[7:0] = ind_rdata;
         `PCS_IDX_PC_LOW: prdata_nxt[7:0] = pc_r[7:0];
         `PCS_IDX_BANK: prdata_nxt[`PCS_BANK_BIT] = bank_r;
         `PCS_IDX_POINTER: prdata_nxt[7:0] = pointer_r;
         `PCS_IDX_PC_LATCH: prdata_nxt[`PCS_LATCH_W-1:0] = pc_high_latch_r;
         `PCS_IDX_PERIPH_FLAG: begin
            prdata_nxt[`PCS_PF_PORT_BIT] = port_transfer_flag_r;
            prdata_nxt[`PCS_PF_CMP_BIT] = compare_change_flag_r;
         end
         `PCS_IDX_RESET_CAUSE: begin
            prdata_nxt[`PCS_RC_PARITY_EN_BIT] = parity_check_fuse;
            prdata_nxt[`PCS_RC_PARITY_BIT] = parity_status_r;
            prdata_nxt[`PCS_RC_POWERON_BIT] = poweron_status_r;
            prdata_nxt[`PCS_RC_BROWNOUT_BIT] = brownout_reset_status_r;
         end
         default: prdata_nxt = `PCS_WORD_ZERO;
      endcase
   end

   // Read data, registered at the setup edge and held through access
   always @(posedge clk_sys) begin
      if (rst) begin
         prdata <= `PCS_WORD_ZERO;
      end else if (rd_setup) begin
         prdata <= prdata_nxt;
      end
   end

endmodule // pcs_core

// ### bench/pcs_core_monitor.sv
`timescale 1ns/1ns
module pcs_core_monitor (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Bus
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] prdata,
   // Fuse and reset events
   input wire parity_check_fuse,
   input wire poweron_rst_evt,
   input wire brownout_rst_evt,
   input wire parity_rst_evt,
   // Decoder
   input wire fetch_inc,
   input wire call_en,
   input wire goto_en,
   input wire [10:0] branch_target,
   input wire return_en,
   input wire irq_vector_en,
   input wire pc_low_load,
   input wire [7:0] pc_low_data,
   input wire [12:0] pc
);
   // Requests that win the priority order
   wire ev = poweron_rst_evt | brownout_rst_evt | parity_rst_evt;
   wire c_ok = call_en & !ev & !irq_vector_en;
   wire g_ok = c_ok ? 1'b0 : goto_en & !ev & !irq_vector_en;
   wire r_ok = return_en & !ev & !irq_vector_en & !call_en & !goto_en;
   wire l_ok = pc_low_load & !ev & !irq_vector_en & !call_en & !goto_en & !return_en;
   wire acc = psel & penable;
   wire f_ok = fetch_inc & !ev & !irq_vector_en & !call_en & !goto_en & !return_en
      & !pc_low_load & !(acc & pwrite & paddr == 32'h0000_0008);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_evt_clears_pc:
      assert property (ev |=> pc == 13'h0000) else $error("pc not cleared");
   a_fetch_step:
      assert property (f_ok |=> pc == $past(pc) + 13'h0001) else $error("fetch step");
   a_jump_target:
      assert property (g_ok |=> pc[10:0] == $past(branch_target) && !pc[12])
      else $error("jump target");
   a_irq_vector:
      assert property (irq_vector_en & !ev |=> pc == 13'h0004) else $error("vector");
   a_call_return:
      assert property (c_ok ##1 r_ok |=> pc == $past(pc, 2)) else $error("return address");
   a_low_load:
      assert property (l_ok |=> pc[7:0] == $past(pc_low_data) && !pc[12])
      else $error("low byte load");
   a_flag_unused:
      assert property (acc & !pwrite & paddr == 32'h0000_0030 |-> prdata[5:0] == 6'h00)
      else $error("flag low bits");
   a_fuse_mirror:
      assert property (acc & !pwrite & paddr == 32'h0000_0238 & $stable(parity_check_fuse)
         |-> prdata[7] == parity_check_fuse) else $error("fuse mirror");
endmodule // pcs_core_monitor

// ### bench/pcs_core_test.sv
`timescale 1ns/1ns
module pcs_core_test;
   // Stimulus and observed signals
   logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd;
   logic pfuse = 0, bfuse = 1;
   logic [1:0] cmp = 2'h0;
   logic [9:0] op = 10'h000;
   logic [10:0] tgt = 11'h000;
   logic [7:0] ldat = 8'h00;
   logic [12:0] stk [8], cur;
   logic [2:0] sp;
   wire pready, pslverr;
   wire [31:0] prdata;
   wire [12:0] pc;
   wire [8:0] ind_addr;
   int fail_count = 0, checks_done = 0;
   always #5 clk_sys = ~clk_sys;
   pcs_core DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .pslverr, .prdata, .poweron_rst_evt(op[6]), .brownout_rst_evt(op[7]),
      .parity_rst_evt(op[8]), .parity_check_fuse(pfuse), .brownout_detect_fuse(bfuse),
      .port_transfer_evt(op[9]), .cmp_out(cmp), .fetch_inc(op[0]), .call_en(op[1]),
      .goto_en(op[2]), .branch_target(tgt), .return_en(op[3]), .irq_vector_en(op[4]),
      .pc_low_load(op[5]), .pc_low_data(ldat), .pc, .ind_addr);
   // Compare and count
   task chk(string n, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // One APB transfer, held until pready
   task apb(logic w, logic [31:0] a, logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rdc(logic [31:0] a, logic [31:0] e);
      apb(0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
   endtask
   // Decoder strobes, one edge each
   task step(logic [9:0] o);
      @(posedge clk_sys);
      op <= o;
   endtask
   task pcis(logic [12:0] e);
      step(10'h000);
      #1 chk("pc", e, pc);
   endtask
   task close_out;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task t_reset;
      chk("pc", 32'h0, pc);
      rdc(32'h238, 32'h04);
      rdc(32'h30, 32'h0);
   endtask
   task t_flags;
      step(10'h200);
      step(10'h000);
      cmp <= 2'h1;
      rdc(32'h30, 32'hC0);
      apb(1, 32'h30, 32'hFF);
      rdc(32'h30, 32'hC0);
      apb(1, 32'h30, 32'h0);
      rdc(32'h30, 32'h0);
   endtask
   task t_cause;
      apb(1, 32'h238, 32'hFF);
      rdc(32'h238, 32'h07);
      step(10'h001);
      step(10'h100);
      pcis(13'h0000);
      rdc(32'h238, 32'h03);
      step(10'h080);
      step(10'h000);
      rdc(32'h238, 32'h02);
      step(10'h040);
      step(10'h000);
      pfuse <= 1;
      rdc(32'h238, 32'h80);
      apb(1, 32'h238, 32'h07);
      step(10'h040);
      step(10'h000);
      rdc(32'h238, 32'h85);
      apb(1, 32'h238, 32'h07);
      bfuse <= 0;
      step(10'h080);
      step(10'h000);
      rdc(32'h238, 32'h87);
   endtask
   task t_pc;
      apb(1, 32'h28, 32'h1F);
      ldat <= 8'hFE;
      step(10'h020);
      pcis(13'h0FFE);
      step(10'h001);
      step(10'h001);
      pcis(13'h1000);
      tgt <= 11'h7FF;
      step(10'h004);
      pcis(13'h0FFF);
      apb(1, 32'h08, 32'h34);
      #1 chk("pc", 32'h0F34, pc);
      rdc(32'h08, 32'h34);
   endtask
   task t_stack;
      apb(1, 32'h28, 32'h08);
      ldat <= 8'h00;
      step(10'h020);
      pcis(13'h0800);
      step(10'h010);
      pcis(13'h0004);
      step(10'h008);
      pcis(13'h0800);
      step(10'h002);
      step(10'h008);
      pcis(13'h0800);
      cur = 13'h0800;
      sp = 3'h0;
      for (int k = 1; k < 10; k++) begin
         step(10'h002);
         tgt <= 11'(k * 16);
         stk[sp] = cur;
         sp++;
         cur = {2'h1, 11'(k * 16)};
      end
      pcis(cur);
      for (int k = 0; k < 9; k++) begin
         step(10'h008);
         sp--;
         cur = stk[sp];
         pcis(cur);
      end
      rdc(32'h28, 32'h08);
   endtask
   task t_ind;
      apb(1, 32'h10, 32'h25);
      apb(1, 32'h0C, 32'h80);
      #1 chk("ind", 32'h125, ind_addr);
      apb(1, 32'h0, 32'hA5);
      rdc(32'h0, 32'hA5);
      apb(1, 32'h10, 32'h80);
      apb(1, 32'h0, 32'h5A);
      rdc(32'h0, 32'h0);
      apb(1, 32'h10, 32'h25);
      rdc(32'h0, 32'hA5);
      apb(0, 32'h3FC, 32'h0);
      chk("err", 32'h1, err);
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 0;
      t_reset;
      t_flags;
      t_cause;
      t_pc;
      t_stack;
      t_ind;
      close_out;
   end
   // Watchdog
   initial begin
      #200000;
      fail_count++;
      close_out;
   end
endmodule // pcs_core_test
bind pcs_core pcs_core_monitor u_mon (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
   .prdata, .parity_check_fuse, .poweron_rst_evt, .brownout_rst_evt, .parity_rst_evt,
   .fetch_inc, .call_en, .goto_en, .branch_target, .return_en, .irq_vector_en,
   .pc_low_load, .pc_low_data, .pc);
